/* rtl/aom_pkg.sv */
// Package: offsets, field layout, reset values and carriers of the operating mode bank
package aom_pkg;

  localparam int unsigned AOM_ADDR_W = 15;
  localparam int unsigned AOM_DATA_W = 8;
  localparam int unsigned AOM_NUM_REGS = 4;

  localparam logic [14:0] AOM_OFS_OPMODE_ONE = 15'h0012;
  localparam logic [14:0] AOM_OFS_OPMODE_TWO = 15'h0013;
  localparam logic [14:0] AOM_OFS_TRIM_CHAN_A = 15'h0014;
  localparam logic [14:0] AOM_OFS_TRIM_CHAN_B = 15'h0015;

  localparam logic [7:0] AOM_RST_OPMODE_ONE = 8'h81;
  localparam logic [7:0] AOM_RST_OPMODE_TWO = 8'h40;
  localparam logic [7:0] AOM_RST_TRIM_CHAN_A = 8'h00;
  localparam logic [7:0] AOM_RST_TRIM_CHAN_B = 8'h00;

  // Operating mode one fields
  localparam int unsigned AOM_FMT_BIT = 7;
  localparam int unsigned AOM_IDLE_LSB = 3;
  localparam int unsigned AOM_GATE_BIT = 2;
  // Operating mode two fields
  localparam int unsigned AOM_DIV_LSB = 3;
  // Trim fields
  localparam int unsigned AOM_AMP_LSB = 4;
  localparam int unsigned AOM_PH_LSB = 0;

  localparam logic [1:0] AOM_IDLE_CODE_NONE = 2'h0;
  localparam logic [1:0] AOM_IDLE_CODE_LOW = 2'h1;
  localparam logic [1:0] AOM_IDLE_CODE_HIGH = 2'h2;

  localparam logic [2:0] AOM_AMP_CODE_RSVD = 3'h4;
  localparam logic [3:0] AOM_DIV_BASE = 4'h1;
  localparam logic [2:0] AOM_PH_STEP_MAX = 3'h7;

  typedef enum logic [1:0] {
    AOM_IDLE_NONE,
    AOM_IDLE_LOW,
    AOM_IDLE_HIGH,
    AOM_IDLE_RSVD
  } aom_idle_t;

  typedef struct packed {
    logic en;
    logic [14:0] addr;
    logic [7:0] data;
  } aom_wr_t;

  typedef struct packed {
    logic [1:0] amp_steps;
    logic amp_pos_up;
    logic amp_rsvd;
    logic [2:0] ph_steps;
    logic ph_neg;
  } aom_trim_t;

endpackage : aom_pkg

/* rtl/aom_regs.sv */
// Operating mode register bank with decoded controls and gated SYSREF edge detect
`timescale 1ns/1ns
`default_nettype none
module aom_regs
  import aom_pkg::*;
#(
  parameter int unsigned NUM_CHAN = 2
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic soft_reset_bit,
  input wire aom_wr_t wr,
  input wire logic rd_en,
  input wire logic [14:0] rd_addr,
  input wire logic sysref_in,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic sample_format_sel,
  output aom_idle_t sysref_idle_mode,
  output logic sysref_gate_on,
  output logic sysref_edge,
  output logic [1:0] sample_clock_divide,
  output logic [3:0] clock_divide_ratio,
  output logic [7:0] trim_code_chan_a,
  output logic [7:0] trim_code_chan_b,
  output aom_trim_t [NUM_CHAN-1:0] trim_decoded
);

  // Register index of a bank address, or out of range
  function automatic logic [2:0] reg_index(input logic [14:0] addr);
    unique case (addr)
      AOM_OFS_OPMODE_ONE: reg_index = 3'h0;
      AOM_OFS_OPMODE_TWO: reg_index = 3'h1;
      AOM_OFS_TRIM_CHAN_A: reg_index = 3'h2;
      AOM_OFS_TRIM_CHAN_B: reg_index = 3'h3;
      default: reg_index = 3'h4;
    endcase
  endfunction : reg_index

  function automatic logic [7:0] reg_reset(input int unsigned idx);
    unique case (idx)
      0: reg_reset = AOM_RST_OPMODE_ONE;
      1: reg_reset = AOM_RST_OPMODE_TWO;
      2: reg_reset = AOM_RST_TRIM_CHAN_A;
      default: reg_reset = AOM_RST_TRIM_CHAN_B;
    endcase
  endfunction : reg_reset

  // SYSREF idle offset of a two-bit code, code 11 reserved
  function automatic aom_idle_t idle_decode(input logic [1:0] code);
    unique case (code)
      AOM_IDLE_CODE_NONE: idle_decode = AOM_IDLE_NONE;
      AOM_IDLE_CODE_LOW: idle_decode = AOM_IDLE_LOW;
      AOM_IDLE_CODE_HIGH: idle_decode = AOM_IDLE_HIGH;
      default: idle_decode = AOM_IDLE_RSVD;
    endcase
  endfunction : idle_decode

  // Divide ratio of a two-bit divide code: 1, 2, 4 or 8
  function automatic logic [3:0] div_ratio(input logic [1:0] code);
    div_ratio = AOM_DIV_BASE << code;
  endfunction : div_ratio

  // Decoded reset values, taken from the register defaults
  localparam aom_idle_t IDLE_RST_VAL = idle_decode(AOM_RST_OPMODE_ONE[AOM_IDLE_LSB +: 2]);
  localparam logic [3:0] RATIO_RST_VAL = div_ratio(AOM_RST_OPMODE_TWO[AOM_DIV_LSB +: 2]);

  logic [7:0] regs_r [AOM_NUM_REGS];
  logic [7:0] regs_nxt [AOM_NUM_REGS];
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;

  // Register storage: write, hold, soft reset
  always_comb begin
    wr_idx = reg_index(wr.addr);
    for (int i = 0; i < AOM_NUM_REGS; i++) begin
      regs_nxt[i] = regs_r[i];
      if (soft_reset_bit) begin
        regs_nxt[i] = reg_reset(i);
      end else if (wr.en && (wr_idx == 3'(i))) begin
        regs_nxt[i] = wr.data;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      regs_r[0] <= AOM_RST_OPMODE_ONE;
      regs_r[1] <= AOM_RST_OPMODE_TWO;
      regs_r[2] <= AOM_RST_TRIM_CHAN_A;
      regs_r[3] <= AOM_RST_TRIM_CHAN_B;
    end else begin
      for (int i = 0; i < AOM_NUM_REGS; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  // Readback, unmapped addresses read zero
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;

  always_comb begin
    rd_idx = reg_index(rd_addr);
    rd_valid_nxt = rd_en;
    rd_data_nxt = 8'h00;
    if (rd_en && (rd_idx < 3'(AOM_NUM_REGS))) begin
      rd_data_nxt = regs_r[rd_idx[1:0]];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // Decoded control outputs, aligned with the stored bytes
  aom_trim_t [NUM_CHAN-1:0] trim_nxt;
  aom_trim_t [NUM_CHAN-1:0] trim_r;
  logic fmt_r;
  logic fmt_nxt;
  aom_idle_t idle_r;
  aom_idle_t idle_nxt;
  logic gate_r;
  logic gate_nxt;
  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic [3:0] ratio_r;
  logic [3:0] ratio_nxt;
  logic [1:0] idle_code;

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_trim
    aom_trim_decode u_dec (
      .trim_reg(regs_nxt[2 + c]),
      .trim(trim_nxt[c])
    );
  end

  always_comb begin
    fmt_nxt = regs_nxt[0][AOM_FMT_BIT];
    gate_nxt = regs_nxt[0][AOM_GATE_BIT];
    idle_code = regs_nxt[0][AOM_IDLE_LSB +: 2];
    idle_nxt = idle_decode(idle_code);
    div_nxt = regs_nxt[1][AOM_DIV_LSB +: 2];
    ratio_nxt = div_ratio(div_nxt);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fmt_r <= AOM_RST_OPMODE_ONE[AOM_FMT_BIT];
      gate_r <= AOM_RST_OPMODE_ONE[AOM_GATE_BIT];
      idle_r <= IDLE_RST_VAL;
      div_r <= AOM_RST_OPMODE_TWO[AOM_DIV_LSB +: 2];
      ratio_r <= RATIO_RST_VAL;
      trim_r <= '0;
    end else begin
      fmt_r <= fmt_nxt;
      gate_r <= gate_nxt;
      idle_r <= idle_nxt;
      div_r <= div_nxt;
      ratio_r <= ratio_nxt;
      trim_r <= trim_nxt;
    end
  end

  // SYSREF pin synchroniser and gated rising edge detect
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic edge_r;
  logic edge_nxt;

  always_comb begin
    edge_nxt = gate_r && sync2_r && !prev_r;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      sync1_r <= sysref_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      edge_r <= edge_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign sample_format_sel = fmt_r;
  assign sysref_idle_mode = idle_r;
  assign sysref_gate_on = gate_r;
  assign sysref_edge = edge_r;
  assign sample_clock_divide = div_r;
  assign clock_divide_ratio = ratio_r;
  assign trim_code_chan_a = regs_r[2];
  assign trim_code_chan_b = regs_r[3];
  assign trim_decoded = trim_r;

endmodule : aom_regs
`default_nettype wire

/* rtl/aom_trim_decode.sv */
// Imbalance trim code decoder for one channel
`timescale 1ns/1ns
`default_nettype none
module aom_trim_decode
  import aom_pkg::*;
(
  input wire logic [7:0] trim_reg,
  output aom_trim_t trim
);

  logic [2:0] amp_code;
  logic [3:0] ph_code;

  always_comb begin
    amp_code = trim_reg[AOM_AMP_LSB +: 3];
    ph_code = trim_reg[AOM_PH_LSB +: 4];
    trim = '0;
    // Amplitude: 5..7 raise positive side, 1..3 lower it, 4 reserved
    if (amp_code == AOM_AMP_CODE_RSVD) begin
      trim.amp_rsvd = 1'b1;
    end else if (amp_code > AOM_AMP_CODE_RSVD) begin
      trim.amp_pos_up = 1'b1;
      trim.amp_steps = 2'(amp_code - AOM_AMP_CODE_RSVD);
    end else begin
      trim.amp_steps = amp_code[1:0];
    end
    // Phase: 1..7 positive input, 8..15 negative input, capped at seven steps
    if (ph_code[3]) begin
      trim.ph_neg = 1'b1;
      trim.ph_steps = (ph_code[2:0] == AOM_PH_STEP_MAX) ? AOM_PH_STEP_MAX : 3'(ph_code[2:0] + 3'h1);
    end else begin
      trim.ph_steps = ph_code[2:0];
    end
  end

endmodule : aom_trim_decode
`default_nettype wire

/* sim/aom_host.sv */
// Host model of the serial port engine
`timescale 1ns/1ns
`default_nettype none
module aom_host
  import aom_pkg::*;
(
  input wire logic clock,
  output var aom_wr_t wr,
  output var logic rd_en,
  output var logic [14:0] rd_addr,
  input wire logic [7:0] rd_data
);
  initial begin
    wr = '0;
    rd_en = 1'b0;
    rd_addr = '0;
  end
  task automatic put(logic [14:0] a, logic [7:0] v);
    @(negedge clock);
    case (a)
      AOM_OFS_OPMODE_ONE: v[6:0] = {2'h0, v[4:2], 2'h1};
      AOM_OFS_OPMODE_TWO: v = {3'h4, v[4:3], 3'h0};
      default: v[7] = 1'b0;
    endcase
    wr = '{1'b1, a, v};
    @(negedge clock);
    wr.en = 1'b0;
  endtask : put
  task automatic get(logic [14:0] a, output logic [7:0] v);
    @(negedge clock);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clock);
    rd_en = 1'b0;
    v = rd_data;
  endtask : get
endmodule : aom_host
`default_nettype wire

/* sim/aom_regs_properties.sv */
// Checker of the mode bank
`timescale 1ns/1ns
`default_nettype none
module aom_regs_chk
  import aom_pkg::*;
#(
  parameter int unsigned NUM_CHAN = 2
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic soft_reset_bit,
  input wire aom_wr_t wr,
  input wire logic rd_en,
  input wire logic [14:0] rd_addr,
  input wire logic sysref_in,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic sample_format_sel,
  input wire aom_idle_t sysref_idle_mode,
  input wire logic sysref_gate_on,
  input wire logic sysref_edge,
  input wire logic [1:0] sample_clock_divide,
  input wire logic [3:0] clock_divide_ratio,
  input wire logic [7:0] trim_code_chan_a,
  input wire aom_trim_t [NUM_CHAN-1:0] trim_decoded
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic wr_one;
  assign wr_one = wr.en && wr.addr == AOM_OFS_OPMODE_ONE && !soft_reset_bit;
  sequence rise_s;
    !sysref_in ##1 sysref_in;
  endsequence
  chk_fmt_follow: assert property (wr_one |=> sample_format_sel == $past(wr.data[7]))
    else $error("bad format");
  chk_idle_follow: assert property (wr_one |=> sysref_idle_mode == $past(wr.data[4:3]))
    else $error("bad idle");
  chk_sref_pulse: assert property (rise_s ##0 sysref_gate_on [*3] |=> sysref_edge)
    else $error("no pulse");
  chk_sref_gate: assert property (sysref_edge |-> $past(sysref_gate_on))
    else $error("gated pulse");
  chk_div_ratio: assert property (clock_divide_ratio == 4'(4'h1 << sample_clock_divide))
    else $error("bad ratio");
  chk_amp_sign: assert property (trim_decoded[0].amp_pos_up == (trim_code_chan_a[6:4] > 3'h4))
    else $error("bad side");
  chk_soft_clear: assert property (soft_reset_bit |=> sample_format_sel && !sysref_gate_on)
    else $error("soft reset");
  chk_read_old: assert property (rd_en && rd_addr == AOM_OFS_TRIM_CHAN_A |=>
    rd_data == $past(trim_code_chan_a)) else $error("bad read");
  chk_read_valid: assert property (rd_en |=> rd_valid)
    else $error("no read valid");
  chk_read_idle: assert property (!rd_en |=> !rd_valid && rd_data == 8'h00)
    else $error("stray read data");
endmodule : aom_regs_chk
bind aom_regs aom_regs_chk #(.NUM_CHAN(NUM_CHAN)) u_chk (.clock, .arst_n, .soft_reset_bit, .wr, .rd_en,
  .rd_addr, .sysref_in, .rd_data, .rd_valid, .sample_format_sel, .sysref_idle_mode, .sysref_gate_on,
  .sysref_edge, .sample_clock_divide, .clock_divide_ratio, .trim_code_chan_a, .trim_decoded);
`default_nettype wire

/* sim/aom_regs_tb_top.sv */
// Bench of the mode bank
`timescale 1ns/1ns
`default_nettype none
module aom_regs_tb_top
  import aom_pkg::*;
;
  logic clock, arst_n, soft_reset_bit, sysref_in, rd_en, rd_valid, sample_format_sel, sysref_gate_on, sysref_edge;
  logic [14:0] rd_addr;
  logic [7:0] rd_data, trim_code_chan_a, trim_code_chan_b, d;
  logic [1:0] sample_clock_divide;
  logic [3:0] clock_divide_ratio;
  aom_wr_t wr;
  aom_idle_t sysref_idle_mode;
  aom_trim_t [1:0] trim_decoded;
  int errors, checks, n;
  aom_regs dut (.clock, .arst_n, .soft_reset_bit, .wr, .rd_en, .rd_addr, .sysref_in, .rd_data, .rd_valid,
    .sample_format_sel, .sysref_idle_mode, .sysref_gate_on, .sysref_edge, .sample_clock_divide,
    .clock_divide_ratio, .trim_code_chan_a, .trim_code_chan_b, .trim_decoded);
  aom_host host (.clock, .wr, .rd_en, .rd_addr, .rd_data);
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // Expected decode of a trim byte, from the code tables
  function automatic aom_trim_t exp_trim(input logic [7:0] v);
    aom_trim_t x;
    x = '0;
    x.amp_rsvd = (v[6:4] == 3'h4);
    x.amp_pos_up = v[6] && (v[5:4] != 2'h0);
    x.amp_steps = x.amp_rsvd ? 2'h0 : v[5:4];
    x.ph_neg = v[3];
    x.ph_steps = !v[3] ? v[2:0] : (v[3:0] == 4'hf) ? 3'h7 : 3'(v[3:0] - 4'h7);
    return x;
  endfunction : exp_trim
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic t_def;
    logic [7:0] e [5] = '{8'h81, 8'h40, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      host.get(AOM_OFS_OPMODE_ONE + 15'(i), d);
      chk("default", 16'(e[i]), 16'(d));
      chk("read valid", 16'h1, 16'(rd_valid));
    end
    @(negedge clock);
    chk("idle read", 16'h0, 16'({rd_valid, rd_data}));
  endtask : t_def
  task automatic t_mode;
    for (int k = 0; k < 4; k++) begin
      host.put(AOM_OFS_OPMODE_ONE, {k[0], 2'h0, 2'(k), k[1], 2'h1});
      host.put(AOM_OFS_OPMODE_TWO, {3'h4, 2'(k), 3'h0});
      chk("format", 16'(k[0]), 16'(sample_format_sel));
      chk("idle", 16'(k), 16'(sysref_idle_mode));
      chk("ratio", 16'h1 << k, 16'(clock_divide_ratio));
      chk("divide", 16'(k), 16'(sample_clock_divide));
      chk("gate", 16'(k[1]), 16'(sysref_gate_on));
      n = 0;
      sysref_in = 1'b1;
      repeat (6) @(negedge clock) n += int'(sysref_edge);
      sysref_in = 1'b0;
      chk("sysref", 16'(k[1]), 16'(n));
      host.get(AOM_OFS_OPMODE_TWO, d);
      chk("mode two", 16'(k * 8 + 128), 16'(d));
    end
  endtask : t_mode
  task automatic t_trim;
    logic [7:0] va;
    logic [7:0] vb;
    for (int i = 0; i < 16; i++) begin
      va = {1'b0, 3'(i), 4'(15 - i)};
      vb = {1'b0, 3'(15 - i), 4'(i)};
      host.put(AOM_OFS_TRIM_CHAN_A, va);
      host.put(AOM_OFS_TRIM_CHAN_B, vb);
      chk("trim a", 16'(exp_trim(va)), 16'(trim_decoded[0]));
      chk("trim b", 16'(exp_trim(vb)), 16'(trim_decoded[1]));
      chk("code a", 16'(va), 16'(trim_code_chan_a));
      chk("code b", 16'(vb), 16'(trim_code_chan_b));
    end
  endtask : t_trim
  // Soft reset in the same cycle as a write; the write is lost
  task automatic t_soft;
    fork
      host.put(AOM_OFS_TRIM_CHAN_A, 8'h55);
      begin
        @(negedge clock) soft_reset_bit = 1'b1;
        @(negedge clock) soft_reset_bit = 1'b0;
      end
    join
    t_def();
  endtask : t_soft
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Tests need well under 2000 cycles
  initial begin
    #20000;
    errors++;
    finish_test();
  end
  initial begin
    arst_n = 1'b0;
    soft_reset_bit = 1'b0;
    sysref_in = 1'b0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    t_def();
    t_mode();
    t_trim();
    t_soft();
    finish_test();
  end
endmodule : aom_regs_tb_top
`default_nettype wire
